// >>> design/i2st_cfg.svh
// Register indices, field positions, reset values and bus constants of the I2C slave transmit block
`ifndef I2ST_CFG_SVH
`define I2ST_CFG_SVH

// Register indices; the byte address on APB is four times the index
`define I2ST_IDX_DATA      12'hf50
`define I2ST_IDX_FLAGS     12'hf51
`define I2ST_IDX_CTRL      12'hf52
`define I2ST_IDX_SADR      12'hf53
`define I2ST_IDX_MODE      12'hf54

// event_flags field positions
`define I2ST_FLG_TXE       7
`define I2ST_FLG_RXF       6
`define I2ST_FLG_HIT       5
`define I2ST_FLG_GC        4
`define I2ST_FLG_RD        3
`define I2ST_FLG_ARB       2
`define I2ST_FLG_SR        1
`define I2ST_FLG_NACK      0

// control_register field positions
`define I2ST_CTL_EN        7
`define I2ST_CTL_START     6
`define I2ST_CTL_STOP      5
`define I2ST_CTL_TXI       3
`define I2ST_CTL_NAK       2
`define I2ST_CTL_FLUSH     1

// Mode register field positions
`define I2ST_MOD_SLA_HI    1:0
`define I2ST_MOD_TEN       2
`define I2ST_MOD_GCE       3
`define I2ST_MOD_MASTER    4
`define I2ST_MOD_RESTART_INDICATOR      7

// Reset values
`define I2ST_RST_DATA      8'h00
`define I2ST_RST_SADR      8'h00
`define I2ST_RST_SLA_HI    2'h0

// Bus address patterns and bit counts
`define I2ST_HDR10         5'h1e
`define I2ST_GC_ADDR       8'h00
`define I2ST_START_BYTE    8'h01
`define I2ST_LAST_BIT      4'h7
`define I2ST_BYTE_BITS     4'h8

`endif

// >>> design/i2st_pkg.sv
// Types shared by the I2C slave transmit block
package i2st_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_RX,
		ST_ACK_OUT,
		ST_TX,
		ST_ACK_IN,
		ST_WAIT
	} i2st_state_t;

	typedef enum logic [1:0] {
		K_ADDR1,
		K_ADDR2,
		K_DATA
	} i2st_kind_t;

	typedef struct packed {
		logic en;
		logic start;
		logic stop;
		logic tx_empty_irq_enable;
		logic nak;
	} i2st_ctrl_t;

	typedef struct packed {
		logic [1:0] sla_hi;
		logic       ten;
		logic       general_call_enable;
		logic       master;
	} i2st_mode_t;

endpackage : i2st_pkg

// >>> design/i2st_slave_tx.sv
// I2C slave transmit path with data buffer, event flags and APB register slave
`timescale 1ns/10ps
`default_nettype none
`include "i2st_cfg.svh"

module i2st_slave_tx (
	input  wire logic        core_clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [13:0] paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	output logic             irq_o
);

	i2st_pkg::i2st_state_t state_q;
	i2st_pkg::i2st_kind_t  kind_q;
	i2st_pkg::i2st_ctrl_t  ctrl_q;
	i2st_pkg::i2st_mode_t  mode_q;

	logic        scl_s1_q, scl_s2_q, scl_s3_q;
	logic        sda_s1_q, sda_s2_q, sda_s3_q;
	logic [7:0]  shift_q;
	logic [3:0]  cnt_q;
	logic        ack_ph_q, loaded_q, got_ack_q, go_tx_q;
	logic        addressed_q, hdr_ok_q;
	logic [7:0]  buf_q;
	logic        buf_full_q;
	logic [7:0]  sla_lo_q;
	logic        rx_full_q, hit_q, gc_q, rd_q, arb_q, sr_q, nack_q, restart_indicator_q;
	logic        pready_q, pslverr_q, irq_q, zero_q;
	logic [31:0] prdata_q;

	// APB decode; the slave answers in the first access cycle
	logic [11:0] idx;
	logic        setup, done, wr_ev, rd_ev, mapped;
	logic        hit_data, hit_flags, hit_ctrl, hit_sadr, hit_mode;
	assign idx       = paddr_i[13:2];
	assign setup     = psel_i & ~penable_i;
	assign done      = psel_i & penable_i & pready_q;
	assign wr_ev     = done & pwrite_i;
	assign rd_ev     = done & ~pwrite_i;
	assign hit_data  = (idx == `I2ST_IDX_DATA);
	assign hit_flags = (idx == `I2ST_IDX_FLAGS);
	assign hit_ctrl  = (idx == `I2ST_IDX_CTRL);
	assign hit_sadr  = (idx == `I2ST_IDX_SADR);
	assign hit_mode  = (idx == `I2ST_IDX_MODE);
	assign mapped    = hit_data | hit_flags | hit_ctrl | hit_sadr | hit_mode;

	// Bus line events, read only from the second synchroniser stage onward
	logic scl_rise, scl_fall, start_ev, stop_ev;
	assign scl_rise = scl_s2_q & ~scl_s3_q;
	assign scl_fall = ~scl_s2_q & scl_s3_q;
	assign start_ev = ~sda_s2_q & sda_s3_q & scl_s2_q;
	assign stop_ev  = sda_s2_q & ~sda_s3_q & scl_s2_q;

	// Address evaluation on the byte being completed
	logic [7:0] rx_byte;
	logic       byte_end, is_hdr, m7, gc_call, a1_hit, a1_ack, a1_next2, a2_hit, byte_ack;
	assign rx_byte  = {shift_q[6:0], sda_s2_q};
	assign byte_end = (state_q == i2st_pkg::ST_RX) & scl_rise & (cnt_q == `I2ST_LAST_BIT);
	assign is_hdr   = mode_q.ten & (rx_byte[7:3] == `I2ST_HDR10) & (rx_byte[2:1] == mode_q.sla_hi);
	assign m7       = ~mode_q.ten & (rx_byte[7:1] == sla_lo_q[6:0]);
	assign gc_call  = mode_q.general_call_enable & ((rx_byte == `I2ST_GC_ADDR) | (rx_byte == `I2ST_START_BYTE));
	assign a1_hit   = m7 | (mode_q.general_call_enable & (rx_byte == `I2ST_GC_ADDR)) | (is_hdr & rx_byte[0] & hdr_ok_q);
	assign a1_next2 = is_hdr & ~rx_byte[0];
	assign a1_ack   = a1_hit | a1_next2;
	assign a2_hit   = (rx_byte == sla_lo_q);
	always_comb begin
		unique case (kind_q)
			i2st_pkg::K_ADDR1: byte_ack = a1_ack;
			i2st_pkg::K_ADDR2: byte_ack = a2_hit;
			default:           byte_ack = ~ctrl_q.nak;
		endcase
	end

	logic ev_first, ev_hit, ev_rx, ev_nack, ev_sr, ev_txe, blocked, rd_flags, start_set, stop_set;
	assign ev_first  = byte_end & (kind_q == i2st_pkg::K_ADDR1);
	assign ev_hit    = byte_end & (((kind_q == i2st_pkg::K_ADDR1) & a1_hit) |
		((kind_q == i2st_pkg::K_ADDR2) & a2_hit));
	assign ev_rx     = byte_end & (kind_q == i2st_pkg::K_DATA);
	assign ev_nack   = (state_q == i2st_pkg::ST_ACK_IN) & scl_rise & sda_s2_q;
	assign ev_sr     = ctrl_q.en & (start_ev | stop_ev) & addressed_q;
	assign ev_txe    = (state_q == i2st_pkg::ST_TX) & loaded_q & scl_rise & (cnt_q == 4'h0);
	assign blocked   = addressed_q & ~rd_q & (state_q != i2st_pkg::ST_IDLE);
	assign rd_flags  = rd_ev & hit_flags;
	assign start_set = wr_ev & hit_ctrl & ctrl_q.en & pwdata_i[`I2ST_CTL_START];
	assign stop_set  = wr_ev & hit_ctrl & ctrl_q.en & pwdata_i[`I2ST_CTL_STOP];

	// Two-stage synchronisers plus one history stage for edge detection
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scl_s1_q <= 1'b1;
			scl_s2_q <= 1'b1;
			scl_s3_q <= 1'b1;
			sda_s1_q <= 1'b1;
			sda_s2_q <= 1'b1;
			sda_s3_q <= 1'b1;
		end else begin
			scl_s1_q <= scl_i;
			scl_s2_q <= scl_s1_q;
			scl_s3_q <= scl_s2_q;
			sda_s1_q <= sda_i;
			sda_s2_q <= sda_s1_q;
			sda_s3_q <= sda_s2_q;
		end
	end

	// Bus sequencer
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_q     <= i2st_pkg::ST_IDLE;
			kind_q      <= i2st_pkg::K_ADDR1;
			shift_q     <= 8'h00;
			cnt_q       <= 4'h0;
			ack_ph_q    <= 1'b0;
			loaded_q    <= 1'b0;
			got_ack_q   <= 1'b0;
			go_tx_q     <= 1'b0;
			addressed_q <= 1'b0;
			hdr_ok_q    <= 1'b0;
			sda_oe_o    <= 1'b0;
			scl_oe_o    <= 1'b0;
		end else if (!ctrl_q.en) begin
			state_q     <= i2st_pkg::ST_IDLE;
			addressed_q <= 1'b0;
			hdr_ok_q    <= 1'b0;
			sda_oe_o    <= 1'b0;
			scl_oe_o    <= 1'b0;
		end else if (start_ev) begin
			// A repeated start keeps the 10-bit header match for the read header
			state_q  <= i2st_pkg::ST_RX;
			kind_q   <= i2st_pkg::K_ADDR1;
			cnt_q    <= 4'h0;
			sda_oe_o <= 1'b0;
			scl_oe_o <= 1'b0;
		end else if (stop_ev) begin
			state_q     <= i2st_pkg::ST_IDLE;
			addressed_q <= 1'b0;
			hdr_ok_q    <= 1'b0;
			sda_oe_o    <= 1'b0;
			scl_oe_o    <= 1'b0;
		end else begin
			unique case (state_q)
				i2st_pkg::ST_IDLE: begin
				end
				i2st_pkg::ST_RX: begin
					if (scl_rise) begin
						shift_q <= rx_byte;
						cnt_q   <= cnt_q + 4'h1;
					end
					if (byte_end) begin
						ack_ph_q <= 1'b0;
						state_q  <= byte_ack ? i2st_pkg::ST_ACK_OUT : i2st_pkg::ST_WAIT;
						if (kind_q == i2st_pkg::K_ADDR1) begin
							addressed_q <= a1_hit;
							go_tx_q     <= a1_hit & rx_byte[0];
							kind_q      <= a1_next2 ? i2st_pkg::K_ADDR2 : i2st_pkg::K_DATA;
							if (!a1_ack) begin
								hdr_ok_q <= 1'b0;
							end
						end else if (kind_q == i2st_pkg::K_ADDR2) begin
							addressed_q <= a2_hit;
							hdr_ok_q    <= a2_hit;
							go_tx_q     <= 1'b0;
							kind_q      <= i2st_pkg::K_DATA;
						end
					end
				end
				i2st_pkg::ST_ACK_OUT: begin
					if (scl_fall) begin
						if (!ack_ph_q) begin
							sda_oe_o <= 1'b1;
							ack_ph_q <= 1'b1;
						end else begin
							sda_oe_o <= 1'b0;
							// Grab SCL at once: waiting a cycle more can find it already released
							scl_oe_o <= go_tx_q & ~buf_full_q;
							cnt_q    <= 4'h0;
							loaded_q <= 1'b0;
							state_q  <= go_tx_q ? i2st_pkg::ST_TX : i2st_pkg::ST_RX;
						end
					end
				end
				i2st_pkg::ST_TX: begin
					if (!loaded_q) begin
						// SCL is low here; hold it until software supplies a byte
						if (buf_full_q) begin
							shift_q  <= buf_q;
							sda_oe_o <= ~buf_q[7];
							loaded_q <= 1'b1;
							scl_oe_o <= 1'b0;
						end else begin
							scl_oe_o <= 1'b1;
						end
					end else begin
						if (scl_rise) begin
							cnt_q <= cnt_q + 4'h1;
						end
						if (scl_fall) begin
							if (cnt_q == `I2ST_BYTE_BITS) begin
								sda_oe_o  <= 1'b0;
								got_ack_q <= 1'b0;
								state_q   <= i2st_pkg::ST_ACK_IN;
							end else begin
								sda_oe_o <= ~shift_q[3'(`I2ST_LAST_BIT - cnt_q)];
							end
						end
					end
				end
				i2st_pkg::ST_ACK_IN: begin
					if (scl_rise) begin
						if (sda_s2_q) begin
							state_q <= i2st_pkg::ST_WAIT;
						end else begin
							got_ack_q <= 1'b1;
						end
					end
					if (scl_fall && got_ack_q) begin
						state_q  <= i2st_pkg::ST_TX;
						scl_oe_o <= ~buf_full_q;
						loaded_q <= 1'b0;
						cnt_q    <= 4'h0;
					end
				end
				i2st_pkg::ST_WAIT: begin
				end
			endcase
		end
	end

	// Data buffer; a write in the same cycle as a consumed byte leaves it full
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			buf_q      <= `I2ST_RST_DATA;
			buf_full_q <= 1'b0;
		end else begin
			if (ev_rx) begin
				buf_q <= rx_byte;
			end
			if (ev_txe || (wr_ev && hit_ctrl && pwdata_i[`I2ST_CTL_FLUSH])) begin
				buf_full_q <= 1'b0;
			end
			if (wr_ev && hit_data && !blocked) begin
				buf_q      <= pwdata_i[7:0];
				buf_full_q <= 1'b1;
			end
		end
	end

	// Control, mode and address registers
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_q   <= '0;
			mode_q   <= '0;
			sla_lo_q <= `I2ST_RST_SADR;
		end else begin
			if (wr_ev && hit_ctrl) begin
				ctrl_q.en  <= pwdata_i[`I2ST_CTL_EN];
				ctrl_q.tx_empty_irq_enable <= pwdata_i[`I2ST_CTL_TXI];
				ctrl_q.nak <= pwdata_i[`I2ST_CTL_NAK];
			end
			// Start and stop can only be set by software; hardware clears them
			if (!ctrl_q.en || addressed_q) begin
				ctrl_q.start <= 1'b0;
				ctrl_q.stop  <= 1'b0;
			end else begin
				if (start_set) begin
					ctrl_q.start <= 1'b1;
				end
				if (stop_set) begin
					ctrl_q.stop <= 1'b1;
				end
			end
			if (wr_ev && hit_mode) begin
				mode_q.sla_hi <= pwdata_i[`I2ST_MOD_SLA_HI];
				mode_q.ten    <= pwdata_i[`I2ST_MOD_TEN];
				mode_q.general_call_enable    <= pwdata_i[`I2ST_MOD_GCE];
				mode_q.master <= pwdata_i[`I2ST_MOD_MASTER];
			end
			if (wr_ev && hit_sadr) begin
				sla_lo_q <= pwdata_i[7:0];
			end
		end
	end

	// Event flags; within each flag a set in the clearing cycle wins, except gc_q and rd_q, where clearing on disable wins
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_full_q <= 1'b0;
			hit_q     <= 1'b0;
			gc_q      <= 1'b0;
			rd_q      <= 1'b0;
			arb_q     <= 1'b0;
			sr_q      <= 1'b0;
			nack_q    <= 1'b0;
			restart_indicator_q    <= 1'b0;
		end else begin
			if (rd_ev && hit_data) begin
				rx_full_q <= 1'b0;
			end
			if (ev_rx && ctrl_q.en) begin
				rx_full_q <= 1'b1;
			end
			if (rd_flags) begin
				hit_q <= 1'b0;
				arb_q <= 1'b0;
				sr_q  <= 1'b0;
			end
			if (ev_hit && ctrl_q.en) begin
				hit_q <= 1'b1;
			end
			if (ctrl_q.en && addressed_q && start_set) begin
				arb_q <= 1'b1;
			end
			if (ev_sr) begin
				sr_q   <= 1'b1;
				restart_indicator_q <= start_ev;
			end
			if (mode_q.master ? (start_set || stop_set) : rd_flags) begin
				nack_q <= 1'b0;
			end
			if (ev_nack && ctrl_q.en && (!mode_q.master || (!ctrl_q.start && !ctrl_q.stop))) begin
				nack_q <= 1'b1;
			end
			if (!ctrl_q.en) begin
				gc_q <= 1'b0;
				rd_q <= 1'b0;
			end else if (ev_first) begin
				gc_q <= gc_call;
				rd_q <= rx_byte[0];
			end
		end
	end

	// Read data mux
	logic [31:0] rd_val;
	always_comb begin
		rd_val = 32'h0000_0000;
		if (hit_data) begin
			rd_val[7:0] = buf_q;
		end
		if (hit_flags) begin
			rd_val[`I2ST_FLG_TXE]  = ~buf_full_q;
			rd_val[`I2ST_FLG_RXF]  = rx_full_q;
			rd_val[`I2ST_FLG_HIT]  = hit_q;
			rd_val[`I2ST_FLG_GC]   = gc_q;
			rd_val[`I2ST_FLG_RD]   = rd_q;
			rd_val[`I2ST_FLG_ARB]  = arb_q;
			rd_val[`I2ST_FLG_SR]   = sr_q;
			rd_val[`I2ST_FLG_NACK] = nack_q;
		end
		if (hit_ctrl) begin
			rd_val[`I2ST_CTL_EN]    = ctrl_q.en;
			rd_val[`I2ST_CTL_START] = ctrl_q.start;
			rd_val[`I2ST_CTL_STOP]  = ctrl_q.stop;
			rd_val[`I2ST_CTL_TXI]   = ctrl_q.tx_empty_irq_enable;
			rd_val[`I2ST_CTL_NAK]   = ctrl_q.nak;
		end
		if (hit_sadr) begin
			rd_val[7:0] = sla_lo_q;
		end
		if (hit_mode) begin
			rd_val[`I2ST_MOD_SLA_HI] = mode_q.sla_hi;
			rd_val[`I2ST_MOD_TEN]    = mode_q.ten;
			rd_val[`I2ST_MOD_GCE]    = mode_q.general_call_enable;
			rd_val[`I2ST_MOD_MASTER] = mode_q.master;
			rd_val[`I2ST_MOD_RESTART_INDICATOR]   = restart_indicator_q;
		end
	end

	// APB answer registered in setup so every output comes from a flop
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= setup;
			pslverr_q <= setup & ~mapped;
			prdata_q  <= (setup & ~pwrite_i) ? rd_val : 32'h0000_0000;
		end
	end

	// Interrupt; address qualifiers gc_q and rd_q are left out on purpose
	always_ff @(posedge core_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_q  <= 1'b0;
			zero_q <= 1'b0;
		end else begin
			irq_q <= ctrl_q.en & ((~buf_full_q & ctrl_q.tx_empty_irq_enable & (state_q != i2st_pkg::ST_RX)) |
				rx_full_q | hit_q | arb_q | sr_q | nack_q);
			zero_q <= 1'b0;
		end
	end

	assign prdata_o  = prdata_q;
	assign pready_o  = pready_q;
	assign pslverr_o = pslverr_q;
	assign irq_o     = irq_q;
	assign scl_o     = zero_q;
	assign sda_o     = zero_q;

endmodule : i2st_slave_tx

`default_nettype wire

// >>> tb/i2st_checker.sv
// Concurrent checks on the ports of the I2C slave transmit block
`timescale 1ns/10ps
`default_nettype none
`include "i2st_cfg.svh"
module i2st_checker (
	input wire logic        core_clk_i,
	input wire logic        rst_n_i,
	input wire logic        psel_i,
	input wire logic        penable_i,
	input wire logic        pwrite_i,
	input wire logic [13:0] paddr_i,
	input wire logic [31:0] prdata_o,
	input wire logic        pready_o,
	input wire logic        pslverr_o,
	input wire logic        scl_oe_o,
	input wire logic        sda_oe_o,
	input wire logic        irq_o
);
	wire logic [11:0] idx = paddr_i[13:2];
	wire logic        acc = psel_i & penable_i & pready_o;
	wire logic        frd = acc & !pwrite_i & (idx == `I2ST_IDX_FLAGS);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);
	setup_answer_a: assert property (psel_i && !penable_i |=> pready_o)
		else $error("no ready after setup");
	ready_pulse_a: assert property (pready_o |=> !pready_o)
		else $error("ready held too long");
	unmapped_err_a: assert property (psel_i && !penable_i && (idx < `I2ST_IDX_DATA || idx > `I2ST_IDX_MODE)
		|=> pslverr_o)
		else $error("no error on unmapped index");
	upper_zero_a: assert property (pready_o && !pwrite_i |-> prdata_o[31:8] == 24'h0)
		else $error("upper read bits not zero");
	// Flags and irq come from the same snapshot, so they must agree in the access cycle
	hit_irq_a: assert property (frd && prdata_o[`I2ST_FLG_HIT] |-> irq_o)
		else $error("address hit without irq");
	quiet_irq_a: assert property (frd && (prdata_o[7:0] & 8'he7) == 8'h00 |-> !irq_o)
		else $error("irq with no source flag");
	stretch_release_a: assert property (scl_oe_o && acc && pwrite_i && idx == `I2ST_IDX_DATA
		|-> ##[1:3] !scl_oe_o)
		else $error("scl still held after buffer write");
	sda_hold_a: assert property ($rose(sda_oe_o) |-> sda_oe_o [*6])
		else $error("sda low too short");
	cover property (scl_oe_o && acc && pwrite_i);
	cover property (frd && prdata_o[`I2ST_FLG_NACK]);
	cover property (pslverr_o);
endmodule : i2st_checker
bind i2st_slave_tx i2st_checker i_i2st_checker (.core_clk_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
	.paddr_i, .prdata_o, .pready_o, .pslverr_o, .scl_oe_o, .sda_oe_o, .irq_o);
`default_nettype wire

// >>> tb/i2st_bfm.sv
// I2C bus master model pulling the open-drain lines low
`timescale 1ns/10ps
`default_nettype none
module i2st_bfm (
	input  wire logic scl_i,
	input  wire logic sda_i,
	output var logic  scl_low_o,
	output var logic  sda_low_o
);
	initial begin
		scl_low_o = 1'b0;
		sda_low_o = 1'b0;
	end
	// Waits on the wire, so a stretching slave only lengthens the low phase
	task automatic clk_bit(input logic b, output logic r);
		#80 sda_low_o = !b;
		#80 scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#160 r = sda_i;
		scl_low_o = 1'b1;
	endtask : clk_bit
	task automatic cond_start;
		#80 sda_low_o = 1'b0;
		#80 scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#160 sda_low_o = 1'b1;
		#160 scl_low_o = 1'b1;
	endtask : cond_start
	task automatic cond_stop;
		#80 sda_low_o = 1'b1;
		#80 scl_low_o = 1'b0;
		wait (scl_i === 1'b1);
		#160 sda_low_o = 1'b0;
		#160;
	endtask : cond_stop
	task automatic send(input logic [7:0] b, output logic a);
		logic r;
		for (int i = 7; i >= 0; i--)
			clk_bit(b[i], r);
		clk_bit(1'b1, r);
		a = !r;
	endtask : send
	task automatic recv(input logic nak, output logic [7:0] b);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			clk_bit(1'b1, r);
			b[i] = r;
		end
		clk_bit(nak, r);
	endtask : recv
endmodule : i2st_bfm
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench for the I2C slave transmit block
`timescale 1ns/10ps
`default_nettype none
`include "i2st_cfg.svh"
module tb_top;
	localparam logic [11:0] IDAT = `I2ST_IDX_DATA;
	localparam logic [11:0] IFLG = `I2ST_IDX_FLAGS;
	localparam logic [11:0] ICTL = `I2ST_IDX_CTRL;
	localparam logic [11:0] IMOD = `I2ST_IDX_MODE;
	logic        clk     = 1'b0;
	logic        rst_n   = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [13:0] paddr   = 14'h0;
	logic [31:0] pwdata  = 32'h0;
	logic [31:0] prdata;
	logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda, ack;
	logic [7:0]  rnd     = 8'h35;
	logic [7:0]  sadr, d;
	logic [32:0] qe[$], qm[$];
	int          num_errors = 0, tests_run = 0, cyc = 0;
	wire logic   scl = !((scl_oe & !scl_o) | m_scl);
	wire logic   sda = !((sda_oe & !sda_o) | m_sda);

	i2st_slave_tx i_i2st_slave_tx (.core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
		.pslverr_o(pslverr), .scl_i(scl), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe), .irq_o(irq));
	i2st_bfm i_i2st_bfm (.scl_i(scl), .sda_i(sda), .scl_low_o(m_scl), .sda_low_o(m_sda));

	initial forever #20 clk = ~clk;
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction : lfsr
	task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic end_sim;
		$display("errors %0d checks %0d", num_errors, tests_run);
		if (num_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim
	task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] v);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {rnd, rnd, rnd, v};
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// The note goes in before the request so the watcher never finds the queue empty
	task automatic rd(input logic [11:0] idx, input logic [8:0] e, input logic [8:0] m);
		qm.push_back({m[8], 24'hffffff, m[7:0]});
		qe.push_back({e[8], 24'h0, e[7:0]} & {m[8], 24'hffffff, m[7:0]});
		apb(1'b0, idx, 8'h00);
	endtask : rd
	always @(posedge clk)
		if (psel && penable && pready === 1'b1 && !pwrite && qm.size() > 0)
			chk("prdata", qe.pop_front(), {pslverr, prdata} & qm.pop_front());
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			num_errors++;
			end_sim();
		end
	end

	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rnd = lfsr(rnd);
		sadr = rnd;
		rd(IFLG, 9'h080, 9'h1ff);
		rd(IDAT, 9'h000, 9'h1ff);
		rd(12'h100, 9'h100, 9'h1ff);
		apb(1'b1, IMOD, 8'h0e);
		apb(1'b1, `I2ST_IDX_SADR, sadr);
		apb(1'b1, ICTL, 8'h80);
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'hf6, ack);
		chk("ack_miss", 0, ack);
		i_i2st_bfm.cond_stop();
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'hf4, ack);
		chk("ack_hdr", 1, ack);
		i_i2st_bfm.send(sadr, ack);
		chk("ack_low", 1, ack);
		chk("irq_hit", 1, irq);
		rd(IFLG, 9'h0a0, 9'h1bb);
		repeat (2) @(posedge clk);
		chk("irq_txi_off", 0, irq);
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'hf5, ack);
		chk("ack_rd_hdr", 1, ack);
		rd(IFLG, 9'h0aa, 9'h1ff);
		rd(IMOD, 9'h08e, 9'h1ff);
		apb(1'b1, ICTL, 8'h88);
		rnd = lfsr(rnd);
		fork
			i_i2st_bfm.recv(1'b0, d);
			begin
				repeat (60) @(posedge clk);
				chk("stretch", 1, scl_oe);
				chk("irq_txe", 1, irq);
				apb(1'b1, IDAT, rnd);
			end
		join
		chk("tx0", rnd, d);
		rnd = lfsr(rnd);
		apb(1'b1, IDAT, rnd);
		i_i2st_bfm.recv(1'b1, d);
		chk("tx1", rnd, d);
		rd(IFLG, 9'h089, 9'h1ff);
		apb(1'b1, ICTL, 8'h82);
		i_i2st_bfm.cond_stop();
		rd(IFLG, 9'h08a, 9'h1ff);
		rd(IMOD, 9'h00e, 9'h1ff);
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'hf4, ack);
		i_i2st_bfm.send(sadr, ack);
		rnd = lfsr(rnd);
		fork
			i_i2st_bfm.send(rnd, ack);
			begin
				repeat (30) @(posedge clk);
				apb(1'b1, IDAT, ~rnd);
			end
		join
		chk("ack_data", 1, ack);
		rd(IFLG, 9'h0c0, 9'h1c0);
		rd(IDAT, {1'b0, rnd}, 9'h1ff);
		rd(IFLG, 9'h000, 9'h140);
		i_i2st_bfm.cond_stop();
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'h00, ack);
		chk("ack_gc", 1, ack);
		rd(IFLG, 9'h030, 9'h13c);
		apb(1'b1, ICTL, 8'hc0);
		rd(IFLG, 9'h014, 9'h11c);
		rd(ICTL, 9'h080, 9'h1e0);
		i_i2st_bfm.cond_stop();
		i_i2st_bfm.cond_start();
		i_i2st_bfm.send(8'h01, ack);
		chk("ack_sbyte", 0, ack);
		rd(IFLG, 9'h018, 9'h118);
		i_i2st_bfm.cond_stop();
		apb(1'b1, ICTL, 8'h00);
		rd(IFLG, 9'h000, 9'h118);
		end_sim();
	end
endmodule : tb_top
`default_nettype wire
